/* File: design/hisf_cfg.svh */
// offsets, field positions, reset values and timing of the host interrupt status block
`ifndef HISF_CFG_SVH
`define HISF_CFG_SVH

// register byte offsets on the apb
`define HISF_ADDR_W         12
`define HISF_OFS_HWMODE     12'h300
`define HISF_OFS_STATUS     12'h310
`define HISF_OFS_ENABLE     12'h314
`define HISF_OFS_PWRDN      12'h320
`define HISF_OFS_ASYNC_AND  12'h330
`define HISF_OFS_ASYNC_OR   12'h334
`define HISF_OFS_PER_AND    12'h338
`define HISF_OFS_PER_OR     12'h33c

// status and enable bit positions, hwmode global enable bit and pwrdn wake field
`define HISF_BIT_ASYNC      8
`define HISF_BIT_PERIODIC   7
`define HISF_BIT_CLKSTABLE  6
`define HISF_BIT_SUSPEND    5
`define HISF_BIT_DMA        3
`define HISF_BIT_LATE       2
`define HISF_BIT_SOF        1
`define HISF_FLAG_MASK      32'h0000_01ea
`define HISF_ENABLE_MASK    32'h0000_01ea
`define HISF_BIT_GLOBAL     0
`define HISF_WAKE_LSB       16
`define HISF_WAKE_MSB       31

// reset values
`define HISF_RST_STATUS     32'h0000_0000
`define HISF_RST_ENABLE     32'h0000_0000
`define HISF_RST_HWMODE     32'h0000_0000
`define HISF_RST_PWRDN      32'h000a_0000
`define HISF_RST_DESC_MASK  32'h0000_0000

// timing
`define HISF_CLK_PERIOD_NS  100
`define HISF_WAKE_UNIT_NS   1000
`define HISF_WAKE_UNIT_CYC  (`HISF_WAKE_UNIT_NS / `HISF_CLK_PERIOD_NS)
`define HISF_LATE_NS        1600
`define HISF_LATE_CYC       ((`HISF_LATE_NS + `HISF_CLK_PERIOD_NS - 1) / `HISF_CLK_PERIOD_NS)

`endif

/* File: design/hisf_pkg.sv */
// types shared by the host interrupt status block
package hisf_pkg;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} hisf_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} hisf_apb_rsp_t;

	typedef struct packed {
		logic dma_done;
		logic sof;
		logic suspend;
	} hisf_evt_t;

	typedef enum logic [3:0] {
		HISF_REG_NONE,
		HISF_REG_HWMODE,
		HISF_REG_STATUS,
		HISF_REG_ENABLE,
		HISF_REG_PWRDN,
		HISF_REG_ASYNC_AND,
		HISF_REG_ASYNC_OR,
		HISF_REG_PER_AND,
		HISF_REG_PER_OR
	} hisf_reg_t;

	typedef enum logic [0:0] {
		HISF_WK_IDLE,
		HISF_WK_RUN
	} hisf_wake_t;

endpackage

/* File: design/hisf_top.sv */
// host interrupt status flags with apb register access
//
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "hisf_cfg.svh"

module hisf_top #(
	parameter int DESC_N = 32
) (
	// clock and reset
	input  wire logic                     clock_i,
	input  wire logic                     sys_rst_i,
	// apb slave
	input  wire hisf_pkg::hisf_apb_req_t  apb_req_i,
	output      hisf_pkg::hisf_apb_rsp_t  apb_rsp_o,
	// transfer descriptor completions, one pulse bit each
	input  wire logic [DESC_N-1:0]        async_done_i,
	input  wire logic [DESC_N-1:0]        periodic_done_i,
	// other events, same clock
	input  wire hisf_pkg::hisf_evt_t      evt_i,
	// clock generator level, other domain
	input  wire logic                     clocks_running_i,
	// interrupt, wake and mode outputs
	output      logic                     irq_o,
	output      logic                     wake_o,
	output      logic                     global_irq_enable_o
);
	import hisf_pkg::*;

	// ************************************************************
	// address decode
	// ************************************************************
	function automatic hisf_reg_t reg_decode(input logic [11:0] addr);
		hisf_reg_t sel;
		unique case (addr)
			`HISF_OFS_HWMODE:    sel = HISF_REG_HWMODE;
			`HISF_OFS_STATUS:    sel = HISF_REG_STATUS;
			`HISF_OFS_ENABLE:    sel = HISF_REG_ENABLE;
			`HISF_OFS_PWRDN:     sel = HISF_REG_PWRDN;
			`HISF_OFS_ASYNC_AND: sel = HISF_REG_ASYNC_AND;
			`HISF_OFS_ASYNC_OR:  sel = HISF_REG_ASYNC_OR;
			`HISF_OFS_PER_AND:   sel = HISF_REG_PER_AND;
			`HISF_OFS_PER_OR:    sel = HISF_REG_PER_OR;
			default:             sel = HISF_REG_NONE;
		endcase
		return sel;
	endfunction

	localparam logic [31:0] DESC_PAD = 32'h0000_0000;

	hisf_apb_rsp_t          rsp_r;
	hisf_reg_t              wr_sel;
	hisf_reg_t              rd_sel;
	logic                   setup_phase;
	logic                   wr_take;
	logic [31:0]            status_r;
	logic [31:0]            status_nxt;
	logic [31:0]            enable_r;
	logic [31:0]            hwmode_r;
	logic [31:0]            pwrdn_r;
	logic [DESC_N-1:0]      and_mask_r [2];
	logic [DESC_N-1:0]      or_mask_r [2];
	logic [DESC_N-1:0]      and_acc_r [2];
	logic [1:0]             list_evt;
	logic [31:0]            set_vec;
	logic [31:0]            clr_vec;
	logic                   clk_meta_r;
	logic                   clk_sync_r;
	logic                   clk_prev_r;
	logic                   susp_prev_r;
	logic                   late_r;
	logic [7:0]             late_cnt_r;
	logic [7:0]             unit_cnt_r;
	logic                   unit_tick;
	hisf_wake_t             wake_state_r;
	logic [15:0]            wake_cnt_r;
	logic                   wake_start;
	logic                   irq_r;

	assign setup_phase = apb_req_i.psel && !apb_req_i.penable;
	assign wr_take     = apb_req_i.psel && apb_req_i.penable && rsp_r.pready
		&& apb_req_i.pwrite;
	assign wr_sel      = wr_take ? reg_decode(apb_req_i.paddr) : HISF_REG_NONE;
	assign rd_sel      = reg_decode(apb_req_i.paddr);

	// ************************************************************
	// apb response: ready and read data prepared in setup phase
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			rsp_r <= '0;
		end
		else
		begin
			rsp_r.pready  <= setup_phase;
			rsp_r.pslverr <= setup_phase && (rd_sel == HISF_REG_NONE);
			rsp_r.prdata  <= 32'h0000_0000;
			if (setup_phase && !apb_req_i.pwrite)
			begin
				unique case (rd_sel)
					HISF_REG_HWMODE:    rsp_r.prdata <= hwmode_r;
					HISF_REG_STATUS:    rsp_r.prdata <= status_r;
					HISF_REG_ENABLE:    rsp_r.prdata <= enable_r;
					HISF_REG_PWRDN:     rsp_r.prdata <= pwrdn_r;
					HISF_REG_ASYNC_AND: rsp_r.prdata <= DESC_PAD | and_mask_r[0];
					HISF_REG_ASYNC_OR:  rsp_r.prdata <= DESC_PAD | or_mask_r[0];
					HISF_REG_PER_AND:   rsp_r.prdata <= DESC_PAD | and_mask_r[1];
					HISF_REG_PER_OR:    rsp_r.prdata <= DESC_PAD | or_mask_r[1];
					HISF_REG_NONE:      rsp_r.prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign apb_rsp_o = rsp_r;

	// ************************************************************
	// control registers
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			enable_r <= `HISF_RST_ENABLE;
			hwmode_r <= `HISF_RST_HWMODE;
			pwrdn_r  <= `HISF_RST_PWRDN;
		end
		else
		begin
			if (wr_sel == HISF_REG_ENABLE)
				enable_r <= apb_req_i.pwdata & `HISF_ENABLE_MASK;
			if (wr_sel == HISF_REG_HWMODE)
				hwmode_r <= apb_req_i.pwdata & 32'h0000_0001;
			if (wr_sel == HISF_REG_PWRDN)
				pwrdn_r <= apb_req_i.pwdata;
		end
	end

	// ************************************************************
	// descriptor lists: 0 async, 1 periodic
	// ************************************************************
	for (genvar l = 0; l < 2; l++)
	begin : g_list
		logic [DESC_N-1:0] done;
		logic [DESC_N-1:0] acc_nxt;
		logic              and_hit;
		logic              or_hit;
		logic              plain_hit;
		hisf_reg_t         and_sel;
		hisf_reg_t         or_sel;

		assign done      = (l == 0) ? async_done_i : periodic_done_i;
		assign and_sel   = (l == 0) ? HISF_REG_ASYNC_AND : HISF_REG_PER_AND;
		assign or_sel    = (l == 0) ? HISF_REG_ASYNC_OR : HISF_REG_PER_OR;
		assign acc_nxt   = and_acc_r[l] | (done & and_mask_r[l]);
		// and group fires once every masked descriptor has completed
		assign and_hit   = (|and_mask_r[l]) && ((acc_nxt & and_mask_r[l]) == and_mask_r[l]);
		assign or_hit    = |(done & or_mask_r[l]);
		// with no group programmed any single completion counts
		assign plain_hit = !(|and_mask_r[l]) && !(|or_mask_r[l]) && (|done);
		assign list_evt[l] = and_hit || or_hit || plain_hit;

		always_ff @(posedge clock_i or posedge sys_rst_i)
		begin
			if (sys_rst_i)
			begin
				and_mask_r[l] <= DESC_N'(`HISF_RST_DESC_MASK);
				or_mask_r[l]  <= DESC_N'(`HISF_RST_DESC_MASK);
				and_acc_r[l]  <= '0;
			end
			else
			begin
				if (wr_sel == or_sel)
					or_mask_r[l] <= apb_req_i.pwdata[DESC_N-1:0];
				// new and mask restarts collection
				if (wr_sel == and_sel)
				begin
					and_mask_r[l] <= apb_req_i.pwdata[DESC_N-1:0];
					and_acc_r[l]  <= '0;
				end
				else if (and_hit)
					and_acc_r[l] <= '0;
				else
					and_acc_r[l] <= acc_nxt;
			end
		end
	end

	// ************************************************************
	// clocks-stable level crosses in from the clock generator
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			clk_meta_r  <= 1'b0;
			clk_sync_r  <= 1'b0;
			clk_prev_r  <= 1'b0;
			susp_prev_r <= 1'b0;
		end
		else
		begin
			clk_meta_r  <= clocks_running_i;
			clk_sync_r  <= clk_meta_r;
			clk_prev_r  <= clk_sync_r;
			susp_prev_r <= evt_i.suspend;
		end
	end

	// ************************************************************
	// status flags
	// ************************************************************
	always_comb
	begin
		set_vec = 32'h0000_0000;
		set_vec[`HISF_BIT_ASYNC]     = list_evt[0];
		set_vec[`HISF_BIT_PERIODIC]  = list_evt[1];
		// generator reports all clocks running, so one edge covers all
		set_vec[`HISF_BIT_CLKSTABLE] = clk_sync_r && !clk_prev_r;
		set_vec[`HISF_BIT_SUSPEND]   = evt_i.suspend && !susp_prev_r;
		set_vec[`HISF_BIT_DMA]       = evt_i.dma_done;
		set_vec[`HISF_BIT_SOF]       = evt_i.sof;
	end

	// reserved positions ignore writes, so a careless write cannot disturb them
	assign clr_vec = (wr_sel == HISF_REG_STATUS) ? (apb_req_i.pwdata & `HISF_FLAG_MASK)
		: 32'h0000_0000;

	// set beats clear; global enable plays no part here
	assign status_nxt = ((status_r & ~clr_vec) | set_vec) & `HISF_FLAG_MASK;

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			status_r <= `HISF_RST_STATUS;
		else
			status_r <= status_nxt | (late_r ? `HISF_FLAG_MASK & 32'h0000_0000 : 32'h0000_0000)
				| ({31'h0000_0000, late_r} << `HISF_BIT_LATE);
	end

	// ************************************************************
	// late reserved bit: zero after reset, one after a short while
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			late_cnt_r <= 8'h00;
			late_r     <= 1'b0;
		end
		else if (!late_r)
		begin
			late_cnt_r <= late_cnt_r + 8'h01;
			if (late_cnt_r == 8'(`HISF_LATE_CYC - 2))
				late_r <= 1'b1;
		end
	end

	// ************************************************************
	// interrupt
	// ************************************************************
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			irq_r <= 1'b0;
		else
			irq_r <= |(status_nxt & enable_r);
	end

	assign irq_o               = irq_r;
	assign global_irq_enable_o = hwmode_r[`HISF_BIT_GLOBAL];

	// ************************************************************
	// wake timer, counted in microsecond ticks
	// ************************************************************
	assign unit_tick  = (unit_cnt_r == 8'(`HISF_WAKE_UNIT_CYC - 1));
	// any completed access by the service routine while suspended, provided the pwrdn wake field is nonzero
	assign wake_start = evt_i.suspend && apb_req_i.psel && apb_req_i.penable && rsp_r.pready
		&& (pwrdn_r[`HISF_WAKE_MSB:`HISF_WAKE_LSB] != 16'h0000);

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			unit_cnt_r <= 8'h00;
		else if (unit_tick || wake_start)
			unit_cnt_r <= 8'h00;
		else
			unit_cnt_r <= unit_cnt_r + 8'h01;
	end

	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
		begin
			wake_state_r <= HISF_WK_IDLE;
			wake_cnt_r   <= 16'h0000;
		end
		else if (wake_start)
		begin
			// a further access restarts the full wake period
			wake_state_r <= HISF_WK_RUN;
			wake_cnt_r   <= pwrdn_r[`HISF_WAKE_MSB:`HISF_WAKE_LSB];
		end
		else
		begin
			unique case (wake_state_r)
				HISF_WK_IDLE:
					wake_cnt_r <= 16'h0000;
				HISF_WK_RUN:
					if (unit_tick)
					begin
						wake_cnt_r <= wake_cnt_r - 16'h0001;
						if (wake_cnt_r == 16'h0001)
							wake_state_r <= HISF_WK_IDLE;
					end
			endcase
		end
	end

	assign wake_o = (wake_state_r == HISF_WK_RUN);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	logic [7:0] chk_age_r;
	always_ff @(posedge clock_i or posedge sys_rst_i)
	begin
		if (sys_rst_i)
			chk_age_r <= 8'h00;
		else if (chk_age_r != 8'hff)
			chk_age_r <= chk_age_r + 8'h01;
	end

	a_async_flag_set: assert property (list_evt[0] |=> status_r[`HISF_BIT_ASYNC])
		else $error("async list event lost");
	a_periodic_flag_set: assert property (
		|(periodic_done_i & or_mask_r[1]) |=> status_r[`HISF_BIT_PERIODIC])
		else $error("periodic or group did not set flag");
	a_irq_gated_enable: assert property (
		(status_r & enable_r) == 32'h0000_0000 && !(|(set_vec & enable_r)) |=> !irq_o)
		else $error("irq without enabled flag");
	a_clk_stable_edge: assert property (
		$rose(clk_sync_r) |=> status_r[`HISF_BIT_CLKSTABLE])
		else $error("clocks stable flag missing");
	a_clk_wait_all: assert property (
		!clk_sync_r && !$past(clk_sync_r) && !status_r[`HISF_BIT_CLKSTABLE] |=>
		!status_r[`HISF_BIT_CLKSTABLE])
		else $error("clocks stable flag before clocks run");
	a_suspend_flag_set: assert property (
		$rose(evt_i.suspend) |=> status_r[`HISF_BIT_SUSPEND])
		else $error("suspend flag missing");
	a_wake_on_access: assert property (wake_start |=> wake_o [*8])
		else $error("wake not held after access in suspend");
	a_wake_ends: assert property (
		wake_o && wake_cnt_r == 16'h0001 && unit_tick && !wake_start |=> !wake_o)
		else $error("wake outlasted programmed time");
	a_dma_flag_set: assert property (evt_i.dma_done |=> status_r[`HISF_BIT_DMA])
		else $error("dma flag missing");
	a_sof_global_off: assert property (
		evt_i.sof && !global_irq_enable_o |=> status_r[`HISF_BIT_SOF])
		else $error("frame start flag missing");
	a_late_bit_delay: assert property (
		(chk_age_r < 8'(`HISF_LATE_CYC) |-> !status_r[`HISF_BIT_LATE])
		and (chk_age_r > 8'(`HISF_LATE_CYC) |-> status_r[`HISF_BIT_LATE]))
		else $error("late reserved bit timing wrong");
	a_w1c_clear_flag: assert property (
		wr_sel == HISF_REG_STATUS |=>
		(status_r & $past(clr_vec & ~set_vec)) == 32'h0000_0000)
		else $error("write one did not clear flag");
	a_irq_or_terms: assert property (
		|(status_r & enable_r) |-> ##[0:1] irq_o)
		else $error("enabled flag did not raise irq");

endmodule

/* File: test/host_irq_status_flags_tb_top.sv */
// self-checking testbench for the host interrupt status flags block
`timescale 1ns/1ps
`include "hisf_cfg.svh"

module host_irq_status_flags_tb_top;
	import hisf_pkg::*;

	// ********************************
	// signals
	// ********************************
	logic              clock_i;
	logic              sys_rst_i;
	hisf_apb_req_t     req;
	hisf_apb_rsp_t     rsp;
	logic [31:0]       async_d;
	logic [31:0]       per_d;
	hisf_evt_t         evt;
	logic              clk_run;
	logic              irq;
	logic              wake;
	logic              gie;
	int                n_fail;
	int                compares;
	int                cyc;
	logic [31:0]       exp_st;
	int                bitpos [6] = '{8, 7, 6, 5, 3, 1};

	hisf_top #(.DESC_N(32)) DUT (
		.clock_i             (clock_i),
		.sys_rst_i           (sys_rst_i),
		.apb_req_i           (req),
		.apb_rsp_o           (rsp),
		.async_done_i        (async_d),
		.periodic_done_i     (per_d),
		.evt_i               (evt),
		.clocks_running_i    (clk_run),
		.irq_o               (irq),
		.wake_o              (wake),
		.global_irq_enable_o (gie)
	);

	// ********************************
	// clock and hang guard
	// ********************************
	initial
	begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	// all tests finish well inside this many cycles
	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_fail++;
			close_out();
		end
	end

	// ********************************
	// tasks
	// ********************************
	task automatic close_out();
		if (n_fail == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		@(posedge clock_i);
		req.psel    <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite  <= wr;
		req.paddr   <= a;
		req.pwdata  <= d;
		@(posedge clock_i);
		req.penable <= 1'b1;
		@(posedge clock_i);
		while (rsp.pready !== 1'b1)
			@(posedge clock_i);
		rd = rsp.prdata;
		err = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, r, e);
		chk(r, exp);
		chk({31'h0000_0000, e}, 32'h0000_0000);
	endtask

	// one-cycle completion pulses on both descriptor lists
	task automatic pulse(input logic [31:0] a, input logic [31:0] p);
		@(posedge clock_i);
		async_d <= a;
		per_d   <= p;
		@(posedge clock_i);
		async_d <= 32'h0000_0000;
		per_d   <= 32'h0000_0000;
		repeat (4) @(posedge clock_i);
	endtask

	// pulses are one cycle; clock and suspend levels stay up
	task automatic fire(input int k);
		@(posedge clock_i);
		case (k)
			0: async_d[0] <= 1'b1;
			1: per_d[0] <= 1'b1;
			2: clk_run <= 1'b1;
			3: evt.suspend <= 1'b1;
			4: evt.dma_done <= 1'b1;
			default: evt.sof <= 1'b1;
		endcase
		@(posedge clock_i);
		async_d      <= 32'h0000_0000;
		per_d        <= 32'h0000_0000;
		evt.dma_done <= 1'b0;
		evt.sof      <= 1'b0;
		repeat (4) @(posedge clock_i);
	endtask

	// ********************************
	// main sequence
	// ********************************
	initial
	begin
		logic [31:0] r;
		logic        e;
		n_fail = 0;
		compares = 0;
		cyc = 0;
		sys_rst_i = 1'b1;
		req = '0;
		async_d = 32'h0000_0000;
		per_d = 32'h0000_0000;
		evt = '0;
		clk_run = 1'b0;
		repeat (12) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0000);
		rd_chk(`HISF_OFS_ENABLE, `HISF_RST_ENABLE);
		rd_chk(`HISF_OFS_PWRDN, `HISF_RST_PWRDN);
		apb(1'b0, 12'h3f0, 32'h0000_0000, r, e);
		chk({31'h0000_0000, e}, 32'h0000_0001);
		chk(r, 32'h0000_0000);
		repeat (20) @(posedge clock_i);
		exp_st = 32'h0000_0004;
		rd_chk(`HISF_OFS_STATUS, exp_st);
		// each event sets its own flag, nothing enabled yet
		for (int k = 0; k < 6; k++)
		begin
			fire(k);
			exp_st[bitpos[k]] = 1'b1;
			rd_chk(`HISF_OFS_STATUS, exp_st);
			chk({30'h0000_0000, irq, gie}, 32'h0000_0000);
		end
		wr(`HISF_OFS_ENABLE, `HISF_ENABLE_MASK);
		repeat (2) @(posedge clock_i);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(`HISF_OFS_STATUS, 32'h0000_00ea);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0104);
		chk({31'h0000_0000, irq}, 32'h0000_0001);
		wr(`HISF_OFS_ENABLE, 32'h0000_00ea);
		repeat (2) @(posedge clock_i);
		chk({31'h0000_0000, irq}, 32'h0000_0000);
		wr(`HISF_OFS_STATUS, 32'h0000_0100);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0004);
		// and group needs both masked completions, or group any one
		wr(`HISF_OFS_ASYNC_AND, 32'h0000_0003);
		fire(0);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0004);
		@(posedge clock_i);
		async_d[1] <= 1'b1;
		@(posedge clock_i);
		async_d <= 32'h0000_0000;
		repeat (3) @(posedge clock_i);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0104);
		wr(`HISF_OFS_STATUS, 32'h0000_0100);
		wr(`HISF_OFS_PER_OR, 32'h0000_0004);
		@(posedge clock_i);
		per_d[2] <= 1'b1;
		@(posedge clock_i);
		per_d <= 32'h0000_0000;
		repeat (3) @(posedge clock_i);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0084);
		// suspend still high: last access starts a 10 us wake period
		repeat (5) @(posedge clock_i);
		chk({31'h0000_0000, wake}, 32'h0000_0001);
		repeat (75) @(posedge clock_i);
		chk({31'h0000_0000, wake}, 32'h0000_0001);
		repeat (40) @(posedge clock_i);
		chk({31'h0000_0000, wake}, 32'h0000_0000);
		// global enable on: flags still latch
		wr(`HISF_OFS_HWMODE, 32'h0000_0001);
		rd_chk(`HISF_OFS_HWMODE, 32'h0000_0001);
		chk({31'h0000_0000, gie}, 32'h0000_0001);
		fire(5);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0086);
		// async or group, periodic and group
		wr(`HISF_OFS_STATUS, 32'h0000_0082);
		wr(`HISF_OFS_ASYNC_OR, 32'h0000_0010);
		wr(`HISF_OFS_PER_OR, 32'h0000_0000);
		wr(`HISF_OFS_PER_AND, 32'h0000_0005);
		rd_chk(`HISF_OFS_ASYNC_OR, 32'h0000_0010);
		rd_chk(`HISF_OFS_PER_AND, 32'h0000_0005);
		pulse(32'h0000_0010, 32'h0000_0001);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0104);
		pulse(32'h0000_0000, 32'h0000_0004);
		rd_chk(`HISF_OFS_STATUS, 32'h0000_0184);
		// shorter wake time applies from the next access on
		wr(`HISF_OFS_PWRDN, 32'h0002_0000);
		rd_chk(`HISF_OFS_PWRDN, 32'h0002_0000);
		repeat (15) @(posedge clock_i);
		chk({31'h0000_0000, wake}, 32'h0000_0001);
		repeat (10) @(posedge clock_i);
		chk({31'h0000_0000, wake}, 32'h0000_0000);
		close_out();
	end
endmodule
